// *** oiir_pkg.sv ***
/*
  Constants, register map, reset defaults and types of the output IIR filter.
  Assumes an APB3 slave with 32-bit data and byte addressing.
*/
// Behaviour
// RULE1 - Preset coefficient sets from 600 to 2500 Hz in 100 Hz steps, a0 4000.
// RULE2 - The 1000 Hz set is a1 C52D, a2 14CE, b0 b2 19FB, b1 33F6.
// RULE3 - Output stage runs in current-loop mode or voltage mode.
// RULE4 - Software writes each setting before the block is put in service.
// RULE5 - DAC configuration resets to 0x00, absolute voltage output.
// RULE6 - Output stage control resets to 0x08, current-loop mode.
// RULE7 - Bridge excitation control resets to 0x00, 2.5 V excitation.
// RULE8 - Pressure gain selection resets to 0x00, 5 V/V.
// RULE9 - Temperature gain selection resets to 0x00, 1.33 V/V.
// RULE10 - Temperature control resets to 0x40; single-ended selector resets to 0x00.
// RULE11 - Temperature single-ended setting resets to 0x00.
// RULE12 - Normal low limit resets to 0x0667, bytes 0x67 and 0x06.
// RULE13 - Normal high limit resets to 0x399a, bytes 0x9a and 0x39.
// RULE14 - Low clamp resets to 0x0334, bytes 0x34 and 0x03.
// RULE15 - High clamp resets to 0x3ccf, bytes 0xcf and 0x3c.
// RULE16 - Software rewrites normal and clamp limits during calibration.
// RULE17 - Diagnostics enable and memory lock both reset to 0x00.
// RULE18 - Front-end diagnostic setup resets to 0x07.
// RULE19 - Front-end diagnostic select resets to 0x33.
// RULE20 - Four customer serial bytes reset to 0x00.
// RULE21 - Software refreshes the checksum byte, reset 0xb8, when diagnostics are on.
// RULE22 - w is a0 x plus a1 w1 plus a2 w2; output is b0 w plus b1 w1 plus b2 w2.
// RULE23 - A zero a0 bypasses the filter.
// RULE24 - Input is clamped between low and high clamp before the filter.
// RULE25 - Coefficients are signed 16-bit fixed point, 0x4000 is unity.
package oiir_pkg;
  localparam int COEF_FRAC = 14;
  localparam int N_PRESETS = 20;
  localparam logic [4:0] PRESET_RST = 5'h04;
  localparam logic [7:0] A_CUTOFF = 8'h00, A_A0 = 8'h04, A_A1 = 8'h08, A_A2 = 8'h0c;
  localparam logic [7:0] A_B0 = 8'h10, A_B1 = 8'h14, A_B2 = 8'h18, A_DACCFG = 8'h1c;
  localparam logic [7:0] A_OPSTAGE = 8'h20, A_BRIDGE = 8'h24, A_PGAIN = 8'h28, A_TGAIN = 8'h2c;
  localparam logic [7:0] A_TCTRL = 8'h30, A_TSE = 8'h34, A_NLOW = 8'h38, A_NHIGH = 8'h3c;
  localparam logic [7:0] A_CLOW = 8'h40, A_CHIGH = 8'h44, A_DIAG = 8'h48, A_LOCK = 8'h4c;
  localparam logic [7:0] A_FESETUP = 8'h50, A_FESEL = 8'h54, A_SERIAL = 8'h58, A_CSUM = 8'h5c;
  localparam logic [7:0] A_STATUS = 8'h60;
  localparam logic [7:0] DACCFG_RST = 8'h00, OPSTAGE_RST = 8'h08, BRIDGE_RST = 8'h00;
  localparam logic [7:0] PGAIN_RST = 8'h00, TGAIN_RST = 8'h00, TCTRL_RST = 8'h40, TSE_RST = 8'h00;
  localparam logic [15:0] NLOW_RST = 16'h0667, NHIGH_RST = 16'h399a;
  localparam logic [15:0] CLOW_RST = 16'h0334, CHIGH_RST = 16'h3ccf;
  localparam logic [7:0] DIAG_RST = 8'h00, LOCK_RST = 8'h00, FESETUP_RST = 8'h07, FESEL_RST = 8'h33;
  localparam logic [31:0] SERIAL_RST = 32'h0000_0000;
  localparam logic [7:0] CSUM_RST = 8'hb8;
  localparam int OPSTAGE_CURRENT_BIT = 3;

  typedef struct packed {
    logic [15:0] a0;
    logic [15:0] a1;
    logic [15:0] a2;
    logic [15:0] b0;
    logic [15:0] b1;
    logic [15:0] b2;
  } oiir_coef_t;

  typedef struct packed {
    logic [7:0] dac_config;
    logic [7:0] output_stage_control;
    logic [7:0] bridge_excitation_ctrl;
    logic [7:0] pressure_gain_select;
    logic [7:0] temperature_gain_select;
    logic [7:0] temperature_control;
    logic [7:0] temperature_single_ended;
    logic [7:0] diagnostics_on;
    logic [7:0] front_end_diag_setup;
    logic [7:0] front_end_diag_select;
  } oiir_cfg_t;

  // Preset coefficient sets, index 0 is 600 Hz
  function automatic oiir_coef_t oiir_preset(input logic [4:0] idx);
    logic [15:0] a1, a2, b0, b1;
    a1 = 16'h0000;
    a2 = 16'h0000;
    b0 = 16'h0000;
    b1 = 16'h0000;
    case (idx)
      5'd0: {a1, a2, b0, b1} = {16'haaa1, 16'h2060, 16'h0b01, 16'h1602};
      5'd1: {a1, a2, b0, b1} = {16'hb169, 16'h1cee, 16'h0e57, 16'h1caf};
      5'd2: {a1, a2, b0, b1} = {16'hb818, 16'h19e0, 16'h11f8, 16'h23f0};
      5'd3: {a1, a2, b0, b1} = {16'hbeae, 16'h172d, 16'h15db, 16'h2bb7};
      5'd4: {a1, a2, b0, b1} = {16'hc52d, 16'h14ce, 16'h19fb, 16'h33f6}; // RULE2
      5'd5: {a1, a2, b0, b1} = {16'hcb95, 16'h12bc, 16'h1e52, 16'h3ca3};
      5'd6: {a1, a2, b0, b1} = {16'hd1ea, 16'h10f2, 16'h22dc, 16'h45b8};
      5'd7: {a1, a2, b0, b1} = {16'hd82d, 16'h0f6a, 16'h2798, 16'h4f2f};
      5'd8: {a1, a2, b0, b1} = {16'hde61, 16'h0e21, 16'h2c82, 16'h5905};
      5'd9: {a1, a2, b0, b1} = {16'he487, 16'h0d14, 16'h319b, 16'h6336};
      5'd10: {a1, a2, b0, b1} = {16'heaa3, 16'h0c3f, 16'h36e2, 16'h6dc4};
      5'd11: {a1, a2, b0, b1} = {16'hf0b6, 16'h0ba1, 16'h3c56, 16'h78ad};
      5'd12: {a1, a2, b0, b1} = {16'hf6c3, 16'h0b37, 16'h41fa, 16'h83f4};
      5'd13: {a1, a2, b0, b1} = {16'hfccc, 16'h0b02, 16'h47ce, 16'h8f9c};
      5'd14: {a1, a2, b0, b1} = {16'h02d4, 16'h0b01, 16'h4dd4, 16'h9ba9};
      5'd15: {a1, a2, b0, b1} = {16'h08dd, 16'h0b33, 16'h540f, 16'ha81f};
      5'd16: {a1, a2, b0, b1} = {16'h0ee9, 16'h0b99, 16'h5a82, 16'hb504};
      5'd17: {a1, a2, b0, b1} = {16'h14fc, 16'h0c33, 16'h612f, 16'hc25e};
      5'd18: {a1, a2, b0, b1} = {16'h1b17, 16'h0d05, 16'h681b, 16'hd037};
      5'd19: {a1, a2, b0, b1} = {16'h213c, 16'h0e0f, 16'h6f4b, 16'hde96};
      default: {a1, a2, b0, b1} = {16'h0000, 16'h0000, 16'h0000, 16'h0000};
    endcase
    return '{a0: 16'h4000, a1: a1, a2: a2, b0: b0, b1: b1, b2: b0}; // RULE1
  endfunction
endpackage

// *** oiir_biquad.sv ***
/*
  Second-order IIR section: a start takes two cycles, then done pulses.
  Assumes coefficients stay stable while a sample is being processed.
*/
module oiir_biquad #(
  parameter int W_W = 22
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               start,
  input  wire logic [15:0]        x_in,
  input  wire oiir_pkg::oiir_coef_t coef,
  output logic                    done,
  output logic [15:0]             y_out
);
  localparam int ACC_W = W_W + 20;
  localparam int MAXW  = (1 << (W_W - 1)) - 1;

  logic               phase_r;
  logic signed [W_W-1:0] w0_r;
  logic signed [W_W-1:0] w1_r;
  logic signed [W_W-1:0] w2_r;
  logic signed [ACC_W-1:0] acc_w;
  logic signed [ACC_W-1:0] acc_y;
  logic               bypass;

  function automatic logic signed [ACC_W-1:0] mac3(input logic [15:0] c0, input logic signed [W_W-1:0] v0,
                                                   input logic [15:0] c1, input logic signed [W_W-1:0] v1,
                                                   input logic [15:0] c2, input logic signed [W_W-1:0] v2);
    mac3 = (ACC_W'($signed(c0)) * ACC_W'(v0) + ACC_W'($signed(c1)) * ACC_W'(v1)
          + ACC_W'($signed(c2)) * ACC_W'(v2)) >>> oiir_pkg::COEF_FRAC; // RULE25
  endfunction

  assign bypass = (coef.a0 == 16'h0000); // RULE23
  assign acc_w  = mac3(coef.a0, W_W'($signed({1'b0, x_in})), coef.a1, w1_r, coef.a2, w2_r); // RULE22
  assign acc_y  = mac3(coef.b0, w0_r, coef.b1, w1_r, coef.b2, w2_r); // RULE22

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= start;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w0_r <= '0;
      w1_r <= '0;
      w2_r <= '0;
    end else if (start) begin
      if (acc_w > ACC_W'(MAXW)) begin
        w0_r <= W_W'(MAXW);
      end else if (acc_w < -ACC_W'(MAXW)) begin
        w0_r <= -W_W'(MAXW);
      end else begin
        w0_r <= acc_w[W_W-1:0];
      end
    end else if (phase_r) begin
      w1_r <= bypass ? '0 : w0_r;
      w2_r <= bypass ? '0 : w1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done  <= 1'b0;
      y_out <= 16'h0000;
    end else begin
      done <= phase_r;
      if (phase_r) begin
        if (bypass) begin
          y_out <= x_in; // RULE23
        end else if (acc_y < 0) begin
          y_out <= 16'h0000;
        end else if (acc_y > ACC_W'(16'hffff)) begin
          y_out <= 16'hffff;
        end else begin
          y_out <= acc_y[15:0];
        end
      end
    end
  end
endmodule

// *** oiir_top.sv ***
/*
  Output stage: APB register file, input clamp, IIR filter and DAC feed.
  Assumes an APB3 master on pclk and a compensation source with valid/ready.
*/
// Chosen here: the register addresses and the APB register port.
module oiir_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                cmp_valid,
  input  wire logic [15:0]         cmp_data,
  output logic                     cmp_ready,
  output logic                     dac_valid,
  output logic [15:0]              dac_data,
  output logic                     current_loop_mode,
  output logic                     voltage_mode,
  output logic                     in_normal_range,
  output oiir_pkg::oiir_cfg_t      analog_cfg
);
  typedef enum logic [1:0] {
    OIIR_IDLE = 2'b00,
    OIIR_CALC = 2'b01,
    OIIR_DONE = 2'b11
  } oiir_state_t;

  oiir_state_t          state_r;
  oiir_state_t          state_nxt;
  oiir_pkg::oiir_coef_t coef_r;
  oiir_pkg::oiir_cfg_t  cfg_r;
  logic [4:0]           cutoff_r;
  logic [15:0]          nlow_r;
  logic [15:0]          nhigh_r;
  logic [15:0]          clow_r;
  logic [15:0]          chigh_r;
  logic [7:0]           lock_r;
  logic [31:0]          serial_r;
  logic [7:0]           csum_r;
  logic [15:0]          sample_r;
  logic [15:0]          clamped;
  logic                 filt_done;
  logic [15:0]          filt_y;
  logic                 setup;
  logic                 access;
  logic                 wr;
  logic                 mapped;
  logic                 bad_cutoff;
  logic                 locked;
  logic [31:0]          rd_mux;

  // Register bus decode
  assign setup      = psel && !penable;
  assign access     = psel && penable;
  assign pready     = 1'b1;
  assign mapped     = (paddr[1:0] == 2'b00) && (paddr <= oiir_pkg::A_STATUS);
  assign bad_cutoff = pwrite && (paddr == oiir_pkg::A_CUTOFF)
                      && (pwdata[4:0] >= 5'(oiir_pkg::N_PRESETS) || pwdata[31:5] != '0);
  assign pslverr    = access && (!mapped || bad_cutoff);
  assign locked     = (lock_r != 8'h00);
  // Lock blocks every write except to the lock setting itself
  assign wr         = access && pwrite && mapped && !bad_cutoff
                      && (!locked || paddr == oiir_pkg::A_LOCK);

  // Coefficients: preset load or direct write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cutoff_r <= oiir_pkg::PRESET_RST;
      coef_r   <= oiir_pkg::oiir_preset(oiir_pkg::PRESET_RST); // RULE2
    end else if (wr) begin
      unique case (paddr)
        oiir_pkg::A_CUTOFF: begin
          cutoff_r <= pwdata[4:0];
          coef_r   <= oiir_pkg::oiir_preset(pwdata[4:0]); // RULE1
        end
        oiir_pkg::A_A0: coef_r.a0 <= pwdata[15:0]; // RULE23
        oiir_pkg::A_A1: coef_r.a1 <= pwdata[15:0];
        oiir_pkg::A_A2: coef_r.a2 <= pwdata[15:0];
        oiir_pkg::A_B0: coef_r.b0 <= pwdata[15:0];
        oiir_pkg::A_B1: coef_r.b1 <= pwdata[15:0];
        oiir_pkg::A_B2: coef_r.b2 <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Analog front-end and output stage settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r.dac_config               <= oiir_pkg::DACCFG_RST; // RULE5
      cfg_r.output_stage_control     <= oiir_pkg::OPSTAGE_RST; // RULE6
      cfg_r.bridge_excitation_ctrl   <= oiir_pkg::BRIDGE_RST; // RULE7
      cfg_r.pressure_gain_select     <= oiir_pkg::PGAIN_RST; // RULE8
      cfg_r.temperature_gain_select  <= oiir_pkg::TGAIN_RST; // RULE9
      cfg_r.temperature_control      <= oiir_pkg::TCTRL_RST; // RULE10
      cfg_r.temperature_single_ended <= oiir_pkg::TSE_RST; // RULE11
      cfg_r.diagnostics_on           <= oiir_pkg::DIAG_RST; // RULE17
      cfg_r.front_end_diag_setup     <= oiir_pkg::FESETUP_RST; // RULE18
      cfg_r.front_end_diag_select    <= oiir_pkg::FESEL_RST; // RULE19
    end else if (wr) begin
      unique case (paddr)
        oiir_pkg::A_DACCFG:  cfg_r.dac_config               <= pwdata[7:0];
        oiir_pkg::A_OPSTAGE: cfg_r.output_stage_control     <= pwdata[7:0]; // RULE3
        oiir_pkg::A_BRIDGE:  cfg_r.bridge_excitation_ctrl   <= pwdata[7:0];
        oiir_pkg::A_PGAIN:   cfg_r.pressure_gain_select     <= pwdata[7:0];
        oiir_pkg::A_TGAIN:   cfg_r.temperature_gain_select  <= pwdata[7:0];
        oiir_pkg::A_TCTRL:   cfg_r.temperature_control      <= pwdata[7:0];
        oiir_pkg::A_TSE:     cfg_r.temperature_single_ended <= pwdata[7:0];
        oiir_pkg::A_DIAG:    cfg_r.diagnostics_on           <= pwdata[7:0];
        oiir_pkg::A_FESETUP: cfg_r.front_end_diag_setup     <= pwdata[7:0];
        oiir_pkg::A_FESEL:   cfg_r.front_end_diag_select    <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Output limits, rewritten by calibration software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nlow_r  <= oiir_pkg::NLOW_RST; // RULE12
      nhigh_r <= oiir_pkg::NHIGH_RST; // RULE13
      clow_r  <= oiir_pkg::CLOW_RST; // RULE14
      chigh_r <= oiir_pkg::CHIGH_RST; // RULE15
    end else if (wr) begin
      unique case (paddr)
        oiir_pkg::A_NLOW:  nlow_r  <= pwdata[15:0];
        oiir_pkg::A_NHIGH: nhigh_r <= pwdata[15:0];
        oiir_pkg::A_CLOW:  clow_r  <= pwdata[15:0];
        oiir_pkg::A_CHIGH: chigh_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Lock, serial number and checksum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r   <= oiir_pkg::LOCK_RST; // RULE17
      serial_r <= oiir_pkg::SERIAL_RST; // RULE20
      csum_r   <= oiir_pkg::CSUM_RST;
    end else if (wr) begin
      unique case (paddr)
        oiir_pkg::A_LOCK:   lock_r   <= pwdata[7:0];
        oiir_pkg::A_SERIAL: serial_r <= pwdata;
        oiir_pkg::A_CSUM:   csum_r   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      oiir_pkg::A_CUTOFF:  rd_mux = {27'h0, cutoff_r};
      oiir_pkg::A_A0:      rd_mux = {16'h0, coef_r.a0};
      oiir_pkg::A_A1:      rd_mux = {16'h0, coef_r.a1};
      oiir_pkg::A_A2:      rd_mux = {16'h0, coef_r.a2};
      oiir_pkg::A_B0:      rd_mux = {16'h0, coef_r.b0};
      oiir_pkg::A_B1:      rd_mux = {16'h0, coef_r.b1};
      oiir_pkg::A_B2:      rd_mux = {16'h0, coef_r.b2};
      oiir_pkg::A_DACCFG:  rd_mux = {24'h0, cfg_r.dac_config};
      oiir_pkg::A_OPSTAGE: rd_mux = {24'h0, cfg_r.output_stage_control};
      oiir_pkg::A_BRIDGE:  rd_mux = {24'h0, cfg_r.bridge_excitation_ctrl};
      oiir_pkg::A_PGAIN:   rd_mux = {24'h0, cfg_r.pressure_gain_select};
      oiir_pkg::A_TGAIN:   rd_mux = {24'h0, cfg_r.temperature_gain_select};
      oiir_pkg::A_TCTRL:   rd_mux = {24'h0, cfg_r.temperature_control};
      oiir_pkg::A_TSE:     rd_mux = {24'h0, cfg_r.temperature_single_ended};
      oiir_pkg::A_NLOW:    rd_mux = {16'h0, nlow_r};
      oiir_pkg::A_NHIGH:   rd_mux = {16'h0, nhigh_r};
      oiir_pkg::A_CLOW:    rd_mux = {16'h0, clow_r};
      oiir_pkg::A_CHIGH:   rd_mux = {16'h0, chigh_r};
      oiir_pkg::A_DIAG:    rd_mux = {24'h0, cfg_r.diagnostics_on};
      oiir_pkg::A_LOCK:    rd_mux = {24'h0, lock_r};
      oiir_pkg::A_FESETUP: rd_mux = {24'h0, cfg_r.front_end_diag_setup};
      oiir_pkg::A_FESEL:   rd_mux = {24'h0, cfg_r.front_end_diag_select};
      oiir_pkg::A_SERIAL:  rd_mux = serial_r;
      oiir_pkg::A_CSUM:    rd_mux = {24'h0, csum_r};
      oiir_pkg::A_STATUS:  rd_mux = {dac_data, 12'h0, locked, in_normal_range,
                                     current_loop_mode, state_r != OIIR_IDLE};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= (!pwrite && mapped) ? rd_mux : 32'h0000_0000;
    end
  end

  // Input clamp
  assign clamped = (cmp_data < clow_r) ? clow_r
                 : (cmp_data > chigh_r) ? chigh_r : cmp_data; // RULE24

  // Sample sequencing
  assign cmp_ready = (state_r == OIIR_IDLE);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      OIIR_IDLE: if (cmp_valid) state_nxt = OIIR_CALC;
      OIIR_CALC: if (filt_done) state_nxt = OIIR_DONE;
      OIIR_DONE: state_nxt = OIIR_IDLE;
      default:   state_nxt = OIIR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= OIIR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_r <= 16'h0000;
    end else if (cmp_valid && cmp_ready) begin
      sample_r <= clamped; // RULE24
    end
  end

  oiir_biquad u_biquad (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (cmp_valid && cmp_ready),
    .x_in    (cmp_ready ? clamped : sample_r),
    .coef    (coef_r),
    .done    (filt_done),
    .y_out   (filt_y)
  );

  // DAC feed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_valid <= 1'b0;
      dac_data  <= 16'h0000;
    end else begin
      dac_valid <= filt_done;
      if (filt_done) begin
        dac_data <= filt_y; // RULE22
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_normal_range <= 1'b0;
    end else if (filt_done) begin
      in_normal_range <= (filt_y >= nlow_r) && (filt_y <= nhigh_r);
    end
  end

  // Output stage mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_loop_mode <= 1'b1;
      voltage_mode      <= 1'b0;
    end else begin
      current_loop_mode <= cfg_r.output_stage_control[oiir_pkg::OPSTAGE_CURRENT_BIT]; // RULE3
      voltage_mode      <= !cfg_r.output_stage_control[oiir_pkg::OPSTAGE_CURRENT_BIT]; // RULE6
    end
  end

  assign analog_cfg = cfg_r;
endmodule

// *** oiir_properties.sv ***
/*
  Port checker bound into oiir_top.
  Assumes one pclk domain, presetn async active low.
*/
module oiir_properties (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                cmp_valid,
  input wire logic [15:0]         cmp_data,
  input wire logic                cmp_ready,
  input wire logic                dac_valid,
  input wire logic [15:0]         dac_data,
  input wire logic                current_loop_mode,
  input wire logic                voltage_mode,
  input wire logic                in_normal_range,
  input wire oiir_pkg::oiir_cfg_t analog_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] nlow_r;
  logic [15:0] nhigh_r;
  logic        lock_r;
  logic        wr_ok;

  assign wr_ok = psel && penable && pwrite && !lock_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nlow_r <= 16'h0667;
      nhigh_r <= 16'h399a;
      lock_r <= 1'b0;
    end else if (wr_ok && paddr == oiir_pkg::A_NLOW) begin
      nlow_r <= pwdata[15:0];
    end else if (wr_ok && paddr == oiir_pkg::A_NHIGH) begin
      nhigh_r <= pwdata[15:0];
    end else if (psel && penable && pwrite && paddr == oiir_pkg::A_LOCK) begin
      lock_r <= pwdata[7:0] != 8'h00;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence take_s;
    cmp_valid && cmp_ready;
  endsequence
  sequence busy_s;
    !cmp_ready [*3] ##1 cmp_ready;
  endsequence
  sequence answer_s;
    !dac_valid [*2] ##1 dac_valid;
  endsequence

  chk_dac_latency: assert property (take_s |=> answer_s)
    else $error("dac_valid late");
  chk_busy_gap: assert property (take_s |=> busy_s)
    else $error("cmp_ready gap");
  chk_dac_pulse: assert property (dac_valid |=> !dac_valid)
    else $error("dac_valid long");
  chk_dac_hold: assert property (!dac_valid |-> $stable(dac_data))
    else $error("dac_data moved");
  chk_mode_pair: assert property (current_loop_mode != voltage_mode)
    else $error("mode pair");
  chk_mode_follows: assert property ($stable(analog_cfg.output_stage_control)
    |-> current_loop_mode == analog_cfg.output_stage_control[3])
    else $error("mode bit");
  chk_normal_flag: assert property (dac_valid
    |-> in_normal_range == (dac_data >= nlow_r && dac_data <= nhigh_r))
    else $error("normal flag");
  chk_cutoff_refused: assert property (wr_ok && paddr == oiir_pkg::A_CUTOFF
    && pwdata >= 32'h14 |-> pslverr)
    else $error("cutoff accepted");
  chk_cfg_reset: assert property ($rose(presetn)
    |-> analog_cfg == 80'h00080000004000000733)
    else $error("cfg defaults");
endmodule

bind oiir_top oiir_properties i_oiir_properties (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .cmp_valid, .cmp_data, .cmp_ready, .dac_valid, .dac_data, .current_loop_mode,
  .voltage_mode, .in_normal_range, .analog_cfg
);

// *** oiir_source.sv ***
/*
  Compensation source and DAC sink.
  Assumes pclk; offers one sample at a time on valid/ready.
*/
module oiir_source (
  input wire logic        pclk,
  input wire logic        cmp_ready,
  output logic            cmp_valid,
  output logic [15:0]     cmp_data,
  input wire logic        dac_valid,
  input wire logic [15:0] dac_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] dac_q [$];

  initial begin
    cmp_valid = 1'b0;
    cmp_data = 16'h5a5a;
  end

  always @(posedge pclk) begin
    if (dac_valid === 1'b1) begin
      dac_q.push_back(dac_data);
    end
  end

  task automatic send(input logic [15:0] d, input int gap);
    repeat (gap) @(posedge pclk);
    cmp_valid <= 1'b1;
    cmp_data <= d;
    @(posedge pclk);
    while (cmp_ready !== 1'b1) @(posedge pclk);
    cmp_valid <= 1'b0;
    cmp_data <= ~d;
    @(posedge pclk);
  endtask
endmodule

// *** output_iir_filter_and_config_defaults_test.sv ***
/*
  Self-checking bench: APB registers and sample stream.
  Assumes oiir_top, oiir_source and the bound checker.
*/
module output_iir_filter_and_config_defaults_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                cmp_valid, cmp_ready, dac_valid;
  logic [15:0]         cmp_data, dac_data;
  logic                current_loop_mode, voltage_mode, in_normal_range;
  oiir_pkg::oiir_cfg_t analog_cfg;
  int                  mismatches, checks_done;
  longint              w1, w2;
  shortint             cf [6] = '{16'h4000, 16'hc52d, 16'h14ce, 16'h19fb, 16'h33f6, 16'h19fb};
  logic [31:0]         top [5] = '{32'h213c, 32'h0e0f, 32'h6f4b, 32'hde96, 32'h6f4b};
  logic [31:0]         dflt [25] = '{32'h4, 32'h4000, 32'hc52d, 32'h14ce, 32'h19fb, 32'h33f6, 32'h19fb,
    32'h0, 32'h8, 32'h0, 32'h0, 32'h0, 32'h40, 32'h0, 32'h667, 32'h399a, 32'h334, 32'h3ccf, 32'h0,
    32'h0, 32'h7, 32'h33, 32'h0, 32'hb8, 32'h2};

  oiir_top i_oiir_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cmp_valid, .cmp_data, .cmp_ready, .dac_valid, .dac_data, .current_loop_mode,
    .voltage_mode, .in_normal_range, .analog_cfg
  );
  oiir_source i_oiir_source (.pclk, .cmp_ready, .cmp_valid, .cmp_data, .dac_valid, .dac_data);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [79:0] exp, input logic [79:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic ee = 1'b0);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), {47'h0, ee, exp}, {47'h0, er, rd});
  endtask

  function automatic logic [15:0] model(input logic [15:0] x);
    longint w, y;
    w = (cf[0] * longint'(x) + cf[1] * w1 + cf[2] * w2) >>> 14;
    w = w > 2097151 ? 2097151 : (w < -2097152 ? -2097152 : w);
    y = (cf[3] * w + cf[4] * w1 + cf[5] * w2) >>> 14;
    w2 = w1;
    w1 = w;
    return y > 65535 ? 16'hffff : (y < 0 ? 16'h0 : 16'(y));
  endfunction

  task automatic flow(input logic [15:0] xs [$], lo, hi, input bit byp);
    logic [15:0] x;
    logic [15:0] eq [$];
    i_oiir_source.dac_q.delete();
    foreach (xs[i]) begin
      x = xs[i] < lo ? lo : (xs[i] > hi ? hi : xs[i]);
      eq.push_back(byp ? x : model(x));
      i_oiir_source.send(xs[i], i % 2);
    end
    while (i_oiir_source.dac_q.size() < eq.size()) @(posedge pclk);
    foreach (eq[i]) check("dac_data", {64'h0, eq[i]}, {64'h0, i_oiir_source.dac_q[i]});
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    final_report();
  end

  initial begin
    {mismatches, checks_done, w1, w2} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("analog_cfg", 80'h00080000004000000733, analog_cfg);
    check("modes", 80'h2, {current_loop_mode, voltage_mode});
    foreach (dflt[i]) rchk(8'(i * 4), dflt[i]);
    $display("test defaults done");
    for (int k = 0; k < 20; k++) begin
      apb(1'b1, oiir_pkg::A_CUTOFF, 32'(k));
      rchk(oiir_pkg::A_A0, 32'h4000);
    end
    foreach (top[j]) rchk(oiir_pkg::A_A1 + 8'(j * 4), top[j]);
    apb(1'b1, oiir_pkg::A_CUTOFF, 32'h14);
    check("cutoff refused", 80'h1, er);
    rchk(oiir_pkg::A_CUTOFF, 32'h13);
    apb(1'b1, oiir_pkg::A_CUTOFF, 32'h4);
    $display("test presets done");
    flow('{16'h2000, 16'h2000, 16'hffff, 16'h0000, 16'h1000, 16'h1000}, 16'h0334, 16'h3ccf, 1'b0);
    $display("test filter done");
    apb(1'b1, oiir_pkg::A_CLOW, 32'h0100);
    apb(1'b1, oiir_pkg::A_NLOW, 32'h0150);
    apb(1'b1, oiir_pkg::A_A0, 32'h0);
    flow('{16'h0120, 16'h0000}, 16'h0100, 16'h3ccf, 1'b1);
    check("in_normal_range", 80'h0, in_normal_range);
    flow('{16'h2000}, 16'h0100, 16'h3ccf, 1'b1);
    check("in_normal_range", 80'h1, in_normal_range);
    $display("test bypass done");
    apb(1'b1, oiir_pkg::A_OPSTAGE, 32'h0);
    @(posedge pclk);
    check("modes", 80'h1, {current_loop_mode, voltage_mode});
    apb(1'b1, oiir_pkg::A_OPSTAGE, 32'h8);
    @(posedge pclk);
    check("modes", 80'h2, {current_loop_mode, voltage_mode});
    $display("test modes done");
    apb(1'b1, oiir_pkg::A_SERIAL, 32'h12345678);
    rchk(oiir_pkg::A_SERIAL, 32'h12345678);
    apb(1'b1, oiir_pkg::A_DIAG, 32'h1);
    apb(1'b1, oiir_pkg::A_CSUM, 32'h5a);
    rchk(oiir_pkg::A_CSUM, 32'h5a);
    apb(1'b1, oiir_pkg::A_LOCK, 32'h1);
    apb(1'b1, oiir_pkg::A_DACCFG, 32'h55);
    rchk(oiir_pkg::A_DACCFG, 32'h0);
    apb(1'b1, oiir_pkg::A_LOCK, 32'h0);
    rchk(8'h64, 32'h0, 1'b1);
    check("unmapped err", 80'h1, er);
    rchk(8'h02, 32'h0, 1'b1);
    check("misaligned err", 80'h1, er);
    $display("test lock done");
    final_report();
  end
endmodule
